/* plas_pkg.sv */
package plas_pkg;

  // Register byte addresses on the processor side
  localparam logic [15:0] ADDR_PORT0   = 16'hFF00;
  localparam logic [15:0] ADDR_PORT2   = 16'hFF02;
  localparam logic [15:0] ADDR_PORT3   = 16'hFF03;
  localparam logic [15:0] ADDR_PORT4   = 16'hFF04;
  localparam logic [15:0] ADDR_PORT12  = 16'hFF0C;
  localparam logic [15:0] ADDR_PORT13  = 16'hFF0D;
  localparam logic [15:0] ADDR_ANASEL  = 16'hFF84;

  // Implemented pin counts per port
  localparam int PORT0_W  = 4;
  localparam int PORT2_W  = 4;
  localparam int PORT3_W  = 5;
  localparam int PORT3_LW = 4;
  localparam int PORT4_W  = 8;
  localparam int PORT12_W = 4;
  localparam int ANASEL_W = 4;
  localparam int PIN_TOT  = PORT0_W + PORT2_W + PORT3_W + PORT4_W + PORT12_W;

  // Bit positions inside the merged pin vector
  localparam int POS_P0  = 0;
  localparam int POS_P2  = POS_P0 + PORT0_W;
  localparam int POS_P3  = POS_P2 + PORT2_W;
  localparam int POS_P4  = POS_P3 + PORT3_W;
  localparam int POS_P12 = POS_P4 + PORT4_W;

  // Alternate-function bit positions
  localparam int BIT_P3_CAPA = 0;
  localparam int BIT_P3_CAPB = 1;
  localparam int BIT_P3_TMR0 = 1;
  localparam int BIT_P4_IRQ3 = 1;
  localparam int BIT_P4_TMRH = 2;
  localparam int BIT_P4_TXD  = 3;
  localparam int BIT_P4_RXD  = 4;

  // Reset values
  localparam logic [7:0] LATCH_RST  = 8'h00;
  localparam logic [7:0] ANASEL_RST = 8'h00;
  localparam logic [7:0] RD_ZERO    = 8'h00;

  // Synchroniser depth for pin levels
  localparam int SYNC_STAGES = 2;

endpackage

/* plas_sync.sv */
`timescale 1ns/10ps
module plas_sync #(
  parameter int WIDTH  = 25,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             resetn_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1 || STAGES < 2) begin : g_chk
    $error("plas_sync needs WIDTH >= 1 and STAGES >= 2");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [STAGES-1:0] chain_r;
    // First stage feeds only the next stage
    always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
        chain_r <= '0;
      end else begin
        chain_r <= {chain_r[STAGES-2:0], async_in[i]};
      end
    end
    assign sync_out[i] = chain_r[STAGES-1];
  end

endmodule

/* plas_anasel.sv */
`timescale 1ns/10ps
module plas_anasel
  import plas_pkg::*;
#(
  parameter int WIDTH = ANASEL_W
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             resetn_in,
  // Write side
  input  wire logic             wr_en_in,
  input  wire logic [7:0]       wr_data_in,
  // Selection bits
  output logic      [WIDTH-1:0] sel_out
);

  if (WIDTH < 1 || WIDTH > 8) begin : g_chk
    $error("plas_anasel WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] sel_r;

  // Upper bits of the byte are dropped, so they stay zero
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_r <= ANASEL_RST[WIDTH-1:0];
    end else if (wr_en_in) begin
      sel_r <= wr_data_in[WIDTH-1:0];
    end
  end

  assign sel_out = sel_r;

endmodule

/* plas_top.sv */
`timescale 1ns/10ps
module plas_top
  import plas_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                resetn_in,
  // Processor access
  input  wire logic [15:0]         cpu_addr_in,
  input  wire logic                cpu_wr_in,
  input  wire logic [7:0]          cpu_wdata_in,
  input  wire logic                cpu_bitwr_in,
  input  wire logic [2:0]          cpu_bitsel_in,
  input  wire logic                cpu_bitval_in,
  input  wire logic                cpu_rd_in,
  output logic      [7:0]          cpu_rdata_out,
  output logic                     cpu_rvalid_out,
  // Direction bits from the direction register block
  input  wire logic [PORT0_W-1:0]  direction_bit_p0_in,
  input  wire logic [PORT2_W-1:0]  direction_bit_p2_in,
  input  wire logic [PORT3_LW-1:0] direction_bit_p3_in,
  input  wire logic [PORT4_W-1:0]  direction_bit_p4_in,
  input  wire logic [PORT12_W-1:0] direction_bit_p12_in,
  // Port 0 pins
  input  wire logic [PORT0_W-1:0]  p0_pin_in,
  output logic      [PORT0_W-1:0]  p0_pin_out,
  output logic      [PORT0_W-1:0]  p0_pin_oe_out,
  // Port 2 pins
  input  wire logic [PORT2_W-1:0]  p2_pin_in,
  output logic      [PORT2_W-1:0]  p2_pin_out,
  output logic      [PORT2_W-1:0]  p2_pin_oe_out,
  // Port 3 pins, bit 4 input only
  input  wire logic [PORT3_W-1:0]  p3_pin_in,
  output logic      [PORT3_LW-1:0] p3_pin_out,
  output logic      [PORT3_LW-1:0] p3_pin_oe_out,
  // Port 4 pins
  input  wire logic [PORT4_W-1:0]  p4_pin_in,
  output logic      [PORT4_W-1:0]  p4_pin_out,
  output logic      [PORT4_W-1:0]  p4_pin_oe_out,
  // Port 12 pins
  input  wire logic [PORT12_W-1:0] p12_pin_in,
  output logic      [PORT12_W-1:0] p12_pin_out,
  output logic      [PORT12_W-1:0] p12_pin_oe_out,
  // Port 13 pin, output only
  output logic                     p13_pin_out,
  // Alternate outputs from peripherals
  input  wire logic                timer0_output_in,
  input  wire logic                timer_h1_output_in,
  input  wire logic                serial_transmit_line_in,
  // Alternate inputs to peripherals
  output logic                     timer0_capture_in_a_out,
  output logic                     timer0_capture_in_b_out,
  output logic                     ext_irq_in0_out,
  output logic                     ext_irq_in1_out,
  output logic                     ext_irq_in2_out,
  output logic                     ext_irq_in3_out,
  output logic                     serial_receive_line_out,
  // Converter side
  output logic      [ANASEL_W-1:0] analog_inputs_sel_out
);

  // Synchronised pin levels
  logic [PIN_TOT-1:0]  pin_raw;
  logic [PIN_TOT-1:0]  pin_sync;
  logic [PORT0_W-1:0]  p0_lvl;
  logic [PORT2_W-1:0]  p2_lvl;
  logic [PORT3_W-1:0]  p3_lvl;
  logic [PORT4_W-1:0]  p4_lvl;
  logic [PORT12_W-1:0] p12_lvl;

  // Output latches
  logic [PORT0_W-1:0]  p0_lat_r;
  logic [PORT2_W-1:0]  p2_lat_r;
  logic [PORT3_LW-1:0] p3_lat_r;
  logic [PORT4_W-1:0]  p4_lat_r;
  logic [PORT12_W-1:0] p12_lat_r;
  logic                p13_lat_r;

  // Pin drive flops
  logic [PORT0_W-1:0]  p0_oe_r;
  logic [PORT2_W-1:0]  p2_oe_r;
  logic [PORT2_W-1:0]  p2_out_r;
  logic [PORT3_LW-1:0] p3_oe_r;
  logic [PORT3_LW-1:0] p3_out_r;
  logic [PORT4_W-1:0]  p4_oe_r;
  logic [PORT4_W-1:0]  p4_out_r;
  logic [PORT12_W-1:0] p12_oe_r;

  // Access path
  logic [ANASEL_W-1:0] ana_sel;
  logic [7:0]          cur_val;
  logic [7:0]          wr_val;
  logic                wr_any;
  logic                ana_wr;
  logic [7:0]          rdata_r;
  logic                rvalid_r;

  assign pin_raw = {p12_pin_in, p4_pin_in, p3_pin_in, p2_pin_in, p0_pin_in};

  plas_sync #(
    .WIDTH  (PIN_TOT),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  (pin_raw),
    .sync_out  (pin_sync)
  );

  assign p0_lvl  = pin_sync[POS_P0  +: PORT0_W];
  assign p2_lvl  = pin_sync[POS_P2  +: PORT2_W];
  assign p3_lvl  = pin_sync[POS_P3  +: PORT3_W];
  assign p4_lvl  = pin_sync[POS_P4  +: PORT4_W];
  assign p12_lvl = pin_sync[POS_P12 +: PORT12_W];

  // Current register view: latch where output, pin where input
  always_comb begin
    cur_val = RD_ZERO;
    unique case (cpu_addr_in)
      ADDR_PORT0: begin
        cur_val[PORT0_W-1:0] = (p0_lat_r & ~direction_bit_p0_in) |
                               (p0_lvl & direction_bit_p0_in);
      end
      ADDR_PORT2: begin
        // Analog pins have no digital input path
        cur_val[PORT2_W-1:0] = (p2_lat_r & ~direction_bit_p2_in) |
                               (p2_lvl & direction_bit_p2_in &
                                ~ana_sel);
      end
      ADDR_PORT3: begin
        cur_val[PORT3_LW-1:0] = (p3_lat_r & ~direction_bit_p3_in) |
                                (p3_lvl[PORT3_LW-1:0] &
                                 direction_bit_p3_in);
        cur_val[PORT3_LW] = p3_lvl[PORT3_LW];
      end
      ADDR_PORT4: begin
        cur_val = (p4_lat_r & ~direction_bit_p4_in) |
                  (p4_lvl & direction_bit_p4_in);
      end
      ADDR_PORT12: begin
        cur_val[PORT12_W-1:0] = (p12_lat_r & ~direction_bit_p12_in) |
                                (p12_lvl & direction_bit_p12_in);
      end
      ADDR_PORT13: begin
        cur_val[0] = p13_lat_r;
      end
      ADDR_ANASEL: begin
        cur_val[ANASEL_W-1:0] = ana_sel;
      end
      default: begin
        cur_val = RD_ZERO;
      end
    endcase
  end

  // Bit write merges into the byte that a read would return now,
  // so input-mode latches take their pin level as a side effect.
  always_comb begin
    wr_val = cpu_wdata_in;
    if (!cpu_wr_in) begin
      wr_val = cur_val;
      wr_val[cpu_bitsel_in] = cpu_bitval_in;
    end
  end

  assign wr_any = cpu_wr_in | cpu_bitwr_in;
  assign ana_wr = wr_any && (cpu_addr_in == ADDR_ANASEL);

  plas_anasel #(
    .WIDTH (ANASEL_W)
  ) u_anasel (
    .clock_in   (clock_in),
    .resetn_in  (resetn_in),
    .wr_en_in   (ana_wr),
    .wr_data_in (wr_val),
    .sel_out    (ana_sel)
  );

  // Output latches
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p0_lat_r <= LATCH_RST[PORT0_W-1:0];
    end else if (wr_any && cpu_addr_in == ADDR_PORT0) begin
      p0_lat_r <= wr_val[PORT0_W-1:0];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p2_lat_r <= LATCH_RST[PORT2_W-1:0];
    end else if (wr_any && cpu_addr_in == ADDR_PORT2) begin
      p2_lat_r <= wr_val[PORT2_W-1:0];
    end
  end

  // Bit 4 has no latch, so its written value is dropped
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p3_lat_r <= LATCH_RST[PORT3_LW-1:0];
    end else if (wr_any && cpu_addr_in == ADDR_PORT3) begin
      p3_lat_r <= wr_val[PORT3_LW-1:0];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p4_lat_r <= LATCH_RST;
    end else if (wr_any && cpu_addr_in == ADDR_PORT4) begin
      p4_lat_r <= wr_val;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p12_lat_r <= LATCH_RST[PORT12_W-1:0];
    end else if (wr_any && cpu_addr_in == ADDR_PORT12) begin
      p12_lat_r <= wr_val[PORT12_W-1:0];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p13_lat_r <= LATCH_RST[0];
    end else if (wr_any && cpu_addr_in == ADDR_PORT13) begin
      p13_lat_r <= wr_val[0];
    end
  end

  // Output enables; registered so pins come straight from flops
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p0_oe_r  <= '0;
      p2_oe_r  <= '0;
      p3_oe_r  <= '0;
      p4_oe_r  <= '0;
      p12_oe_r <= '0;
    end else begin
      p0_oe_r  <= ~direction_bit_p0_in;
      p2_oe_r  <= ~direction_bit_p2_in & ~ana_sel;
      p3_oe_r  <= ~direction_bit_p3_in;
      p4_oe_r  <= ~direction_bit_p4_in;
      p12_oe_r <= ~direction_bit_p12_in;
    end
  end

  // Pin values with alternate outputs merged into the latch.
  // Timer outputs need latch 0, serial transmit needs latch 1.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p2_out_r <= '0;
      p3_out_r <= '0;
      p4_out_r <= '0;
    end else begin
      p2_out_r <= p2_lat_r & ~ana_sel;
      p3_out_r <= p3_lat_r;
      p3_out_r[BIT_P3_TMR0] <= p3_lat_r[BIT_P3_TMR0] |
                               timer0_output_in;
      p4_out_r <= p4_lat_r;
      p4_out_r[BIT_P4_TMRH] <= p4_lat_r[BIT_P4_TMRH] |
                               timer_h1_output_in;
      p4_out_r[BIT_P4_TXD]  <= p4_lat_r[BIT_P4_TXD] &
                               serial_transmit_line_in;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r  <= RD_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= cpu_rd_in;
      if (cpu_rd_in) begin
        rdata_r <= cur_val;
      end
    end
  end

  assign cpu_rdata_out  = rdata_r;
  assign cpu_rvalid_out = rvalid_r;

  assign p0_pin_out     = p0_lat_r;
  assign p0_pin_oe_out  = p0_oe_r;
  assign p2_pin_out     = p2_out_r;
  assign p2_pin_oe_out  = p2_oe_r;
  assign p3_pin_out     = p3_out_r;
  assign p3_pin_oe_out  = p3_oe_r;
  assign p4_pin_out     = p4_out_r;
  assign p4_pin_oe_out  = p4_oe_r;
  assign p12_pin_out    = p12_lat_r;
  assign p12_pin_oe_out = p12_oe_r;
  assign p13_pin_out    = p13_lat_r;

  // Alternate inputs follow the pin whatever the latch holds
  assign timer0_capture_in_a_out = p3_lvl[BIT_P3_CAPA];
  assign ext_irq_in0_out         = p3_lvl[BIT_P3_CAPA];
  assign timer0_capture_in_b_out = p3_lvl[BIT_P3_CAPB];
  assign ext_irq_in2_out         = p3_lvl[BIT_P3_CAPB];
  assign ext_irq_in3_out         = p4_lvl[BIT_P4_IRQ3];
  assign ext_irq_in1_out         = p4_lvl[BIT_P4_TXD];
  assign serial_receive_line_out = p4_lvl[BIT_P4_RXD];

  // Converter takes the pin when selected
  assign analog_inputs_sel_out = ana_sel;

endmodule

/* plas_chk_sva.sv */
`timescale 1ns/10ps
module plas_chk
  import plas_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                resetn_in,
  // Processor access
  input  wire logic [15:0]         cpu_addr_in,
  input  wire logic                cpu_wr_in,
  input  wire logic [7:0]          cpu_wdata_in,
  input  wire logic                cpu_rd_in,
  input  wire logic [7:0]          cpu_rdata_out,
  input  wire logic                cpu_rvalid_out,
  // Pins and select
  input  wire logic [PORT0_W-1:0]  direction_bit_p0_in,
  input  wire logic [PORT2_W-1:0]  direction_bit_p2_in,
  input  wire logic [PORT0_W-1:0]  p0_pin_out,
  input  wire logic [PORT0_W-1:0]  p0_pin_oe_out,
  input  wire logic [PORT2_W-1:0]  p2_pin_oe_out,
  input  wire logic [PORT4_W-1:0]  p4_pin_in,
  input  wire logic                p13_pin_out,
  input  wire logic                serial_receive_line_out,
  input  wire logic [ANASEL_W-1:0] analog_inputs_sel_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_wr(logic [15:0] a);
    cpu_wr_in && cpu_addr_in == a;
  endsequence
  // Pin held long enough to pass both synchroniser stages
  sequence s_rx_steady;
    (resetn_in && $stable(p4_pin_in[BIT_P4_RXD])) [*3];
  endsequence

  property p_reset_clear;
    $rose(resetn_in) |-> p0_pin_out == 4'h0 && !p13_pin_out
      && analog_inputs_sel_out == 4'h0;
  endproperty
  property p_p0_oe;
    1'b1 |=> p0_pin_oe_out == ~$past(direction_bit_p0_in);
  endproperty
  property p_p2_oe;
    1'b1 |=> p2_pin_oe_out ==
      (~$past(direction_bit_p2_in) & ~$past(analog_inputs_sel_out));
  endproperty
  property p_p0_write;
    s_wr(ADDR_PORT0) |=> {4'h0, p0_pin_out} == ($past(cpu_wdata_in) & 8'h0F);
  endproperty
  property p_p13_write;
    s_wr(ADDR_PORT13) |=>
      {7'h00, p13_pin_out} == ($past(cpu_wdata_in) & 8'h01);
  endproperty
  property p_sel_write;
    s_wr(ADDR_ANASEL) |=>
      {4'h0, analog_inputs_sel_out} == ($past(cpu_wdata_in) & 8'h0F);
  endproperty
  property p_sel_read;
    cpu_rd_in && cpu_addr_in == ADDR_ANASEL |=> cpu_rvalid_out
      && cpu_rdata_out == {4'h0, $past(analog_inputs_sel_out)};
  endproperty
  property p_unmapped_read;
    cpu_rd_in && cpu_addr_in == 16'hFF10 |=> cpu_rvalid_out
      && cpu_rdata_out == RD_ZERO;
  endproperty
  property p_rx_follow;
    s_rx_steady |-> serial_receive_line_out == p4_pin_in[BIT_P4_RXD];
  endproperty

  a_reset_clear: assert property (p_reset_clear)
    else $error("latch or select not clear after reset");
  a_p0_oe: assert property (p_p0_oe)
    else $error("port 0 drive enable does not follow direction");
  a_p2_oe: assert property (p_p2_oe)
    else $error("port 2 drive enable wrong for direction or select");
  a_p0_write: assert property (p_p0_write)
    else $error("port 0 pin value differs from written byte");
  a_p13_write: assert property (p_p13_write)
    else $error("port 13 pin differs from written bit");
  a_sel_write: assert property (p_sel_write)
    else $error("select register differs from written byte");
  a_sel_read: assert property (p_sel_read)
    else $error("select read returns wrong value");
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");
  a_rx_follow: assert property (p_rx_follow)
    else $error("serial receive line does not follow its pin");
endmodule

bind plas_top plas_chk plas_chk_inst (
  .clock_in(clock_in), .resetn_in(resetn_in), .cpu_addr_in(cpu_addr_in),
  .cpu_wr_in(cpu_wr_in), .cpu_wdata_in(cpu_wdata_in),
  .cpu_rd_in(cpu_rd_in), .cpu_rdata_out(cpu_rdata_out),
  .cpu_rvalid_out(cpu_rvalid_out),
  .direction_bit_p0_in(direction_bit_p0_in),
  .direction_bit_p2_in(direction_bit_p2_in), .p0_pin_out(p0_pin_out),
  .p0_pin_oe_out(p0_pin_oe_out), .p2_pin_oe_out(p2_pin_oe_out),
  .p4_pin_in(p4_pin_in), .p13_pin_out(p13_pin_out),
  .serial_receive_line_out(serial_receive_line_out),
  .analog_inputs_sel_out(analog_inputs_sel_out)
);

/* plas_pin_model.sv */
`timescale 1ns/10ps
module plas_pin_model #(
  parameter int W = 4
) (
  // Design side
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] drv_in,
  // Outside source or pull level of an undriven pin
  input  wire logic [W-1:0] float_in,
  // Resolved pin level
  output logic      [W-1:0] pin_out
);
  // Undriven pins never keep the last driven value
  assign pin_out = (oe_in & drv_in) | (~oe_in & float_in);
endmodule

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import plas_pkg::*;
();
  logic        clock_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [2:0]  bsel = 3'h0;
  logic        wr = 1'b0, bwr = 1'b0, bval = 1'b0, rd = 1'b0;
  logic        tmr0 = 1'b0, tmrh = 1'b0, txd = 1'b1;
  // Direction lacks p3 bit 4, pin vectors hold it
  logic [23:0] dir = 24'h000000;
  logic [24:0] ext = 25'h0000000;
  wire  [24:0] pin, pout, poe;
  wire  [6:0]  alt;
  wire  [7:0]  rdata;
  wire  [3:0]  sel;
  wire         rvalid, p13;
  int          fail_count = 0;
  int          n_checks = 0;
  logic [15:0] adr [7] = '{ADDR_PORT0, ADDR_PORT2, ADDR_PORT3, ADDR_PORT4,
                           ADDR_PORT12, ADDR_PORT13, ADDR_ANASEL};
  logic [7:0]  msk [7] = '{8'h0F, 8'h0F, 8'h0F, 8'hFF, 8'h0F, 8'h01, 8'h0F};

  assign pout[12] = 1'b0;
  assign poe[12] = 1'b0;
  always #5 clock_in = ~clock_in;

  plas_top plas_top_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .cpu_addr_in(addr),
    .cpu_wr_in(wr), .cpu_wdata_in(wdata), .cpu_bitwr_in(bwr),
    .cpu_bitsel_in(bsel), .cpu_bitval_in(bval), .cpu_rd_in(rd),
    .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid),
    .direction_bit_p0_in(dir[3:0]), .direction_bit_p2_in(dir[7:4]),
    .direction_bit_p3_in(dir[11:8]), .direction_bit_p4_in(dir[19:12]),
    .direction_bit_p12_in(dir[23:20]),
    .p0_pin_in(pin[3:0]), .p0_pin_out(pout[3:0]), .p0_pin_oe_out(poe[3:0]),
    .p2_pin_in(pin[7:4]), .p2_pin_out(pout[7:4]), .p2_pin_oe_out(poe[7:4]),
    .p3_pin_in(pin[12:8]), .p3_pin_out(pout[11:8]),
    .p3_pin_oe_out(poe[11:8]), .p4_pin_in(pin[20:13]),
    .p4_pin_out(pout[20:13]), .p4_pin_oe_out(poe[20:13]),
    .p12_pin_in(pin[24:21]), .p12_pin_out(pout[24:21]),
    .p12_pin_oe_out(poe[24:21]), .p13_pin_out(p13),
    .timer0_output_in(tmr0), .timer_h1_output_in(tmrh),
    .serial_transmit_line_in(txd),
    .timer0_capture_in_a_out(alt[0]), .timer0_capture_in_b_out(alt[1]),
    .ext_irq_in0_out(alt[2]), .ext_irq_in1_out(alt[3]),
    .ext_irq_in2_out(alt[4]), .ext_irq_in3_out(alt[5]),
    .serial_receive_line_out(alt[6]), .analog_inputs_sel_out(sel)
  );
  plas_pin_model #(.W(PIN_TOT)) plas_pin_model_inst (
    .oe_in(poe), .drv_in(pout), .float_in(ext), .pin_out(pin)
  );

  task automatic chk(input string nm, input logic [24:0] e,
                     input logic [24:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Lands one step past the edge so flop updates are visible
  task automatic settle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic wr_bit(input logic [15:0] a, input logic [2:0] b,
                        input logic v);
    @(posedge clock_in);
    addr <= a;
    bsel <= b;
    bval <= v;
    bwr <= 1'b1;
    @(posedge clock_in);
    bwr <= 1'b0;
  endtask
  task automatic rd_byte(input logic [15:0] a, input logic [7:0] e,
                         input string nm);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    chk({nm, " valid"}, 25'h1, {24'h0, rvalid});
    chk(nm, {17'h0, e}, {17'h0, rdata});
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rd_byte(adr[i], 8'h00, "after reset");
    end
    chk("p13 after reset", 25'h0, {24'h0, p13});
  endtask
  task automatic t_out();
    for (int i = 0; i < 7; i++) begin
      wr_byte(adr[i], 8'hFF);
      rd_byte(adr[i], msk[i], "byte rw");
    end
    rd_byte(16'hFF10, 8'h00, "unmapped");
    chk("pin levels", 25'h1FFEF0F, pin);
    chk("drive enables", 25'h1FFEF0F, poe);
    ext[12] <= 1'b1;
    settle(3);
    rd_byte(ADDR_PORT3, 8'h1F, "p3 input only bit");
  endtask
  task automatic t_in();
    wr_byte(ADDR_ANASEL, 8'h00);
    dir <= 24'hFFFFFF;
    ext <= 25'h0A5A5A5;
    settle(4);
    chk("drive off", 25'h0, poe);
    rd_byte(ADDR_PORT0, {4'h0, ext[3:0]}, "p0 in");
    rd_byte(ADDR_PORT2, {4'h0, ext[7:4]}, "p2 in");
    rd_byte(ADDR_PORT3, {3'h0, ext[12:8]}, "p3 in");
    rd_byte(ADDR_PORT4, ext[20:13], "p4 in");
    rd_byte(ADDR_PORT12, {4'h0, ext[24:21]}, "p12 in");
    rd_byte(ADDR_PORT13, 8'h01, "p13 latch");
  endtask
  task automatic t_bit();
    dir[19:12] <= 8'hF0;
    wr_bit(ADDR_PORT4, 3'h0, 1'b0);
    dir[19:12] <= 8'h00;
    settle(2);
    rd_byte(ADDR_PORT4, {ext[20:17], 4'hE}, "p4 bit write");
    wr_bit(ADDR_ANASEL, 3'h2, 1'b1);
    wr_bit(ADDR_ANASEL, 3'h7, 1'b1);
    rd_byte(ADDR_ANASEL, 8'h04, "select bit write");
  endtask
  task automatic t_analog();
    dir[7:4] <= 4'hF;
    ext[7:4] <= 4'hF;
    wr_byte(ADDR_ANASEL, 8'h05);
    settle(3);
    rd_byte(ADDR_PORT2, 8'h0A, "p2 analog read");
    chk("select out", 25'h5, {21'h0, sel});
    dir[7:4] <= 4'h0;
    settle(3);
    chk("p2 analog drive", 25'hA, {21'h0, poe[7:4]});
    // Latch still all ones; selected pins must drive 0
    chk("p2 analog out", 25'hA, {21'h0, pout[7:4]});
  endtask
  task automatic t_alt();
    dir[11:8] <= 4'hD;
    dir[19:12] <= 8'hF3;
    wr_byte(ADDR_PORT3, 8'h00);
    wr_byte(ADDR_PORT4, 8'h08);
    for (int v = 0; v < 2; v++) begin
      tmr0 <= v[0];
      tmrh <= v[0];
      txd <= v[0];
      ext <= {25{v[0]}};
      settle(5);
      chk("alt inputs", {25{v[0]}} & 25'h7F, {18'h0, alt});
      chk("alt outputs", {25{v[0]}} & 25'h7,
          {22'h0, pout[16], pout[15], pout[9]});
    end
  endtask
  task automatic t_rst();
    resetn_in <= 1'b0;
    settle(2);
    resetn_in <= 1'b1;
    rd_byte(ADDR_PORT13, 8'h00, "p13 mid reset");
    rd_byte(ADDR_ANASEL, 8'h00, "select mid reset");
  endtask

  initial begin
    settle(16);
    resetn_in <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_bit();
    t_analog();
    t_alt();
    t_rst();
    end_sim();
  end
  // Whole run needs under 150 cycles
  initial begin
    settle(3000);
    $display("MISMATCH watchdog expected done seen hang");
    fail_count++;
    end_sim();
  end
endmodule
